// File: rtl/sbc_defines.svh
// Constants of the strap boot configuration decoder: register offsets,
// field positions, reset values and the strap capture timing.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH

// Byte offsets of the two APB registers.
`define SBC_STATUS_OFS      12'h000
`define SBC_CONTROL_OFS     12'h004

// Strap vector layout as it arrives on the pins, packed low to high.
`define SBC_STRAP_W         7
`define SBC_CFG_LO          0
`define SBC_CFG_HI          2
`define SBC_CFG_ENDIAN_BIT  2
`define SBC_DBG_BIT         3
`define SBC_REF_LO          4
`define SBC_REF_HI          6

// Reference frequency codes on the strap pins.
`define SBC_REF_125         3'h0
`define SBC_REF_156         3'h1
`define SBC_REF_250         3'h2
`define SBC_REF_25          3'h4

// Reference frequencies in kHz, 18 bits wide.
`define SBC_KHZ_125         18'h1E848
`define SBC_KHZ_156         18'h2625A
`define SBC_KHZ_250         18'h3D090
`define SBC_KHZ_25          18'h061A8

// Control register fields.
`define SBC_CTL_START_BIT   0
`define SBC_CTL_FLASH_BIT   1
`define SBC_CTL_RESET       2'h0

// Status register fields.
`define SBC_ST_CFG_LO       0
`define SBC_ST_DBG_BIT      3
`define SBC_ST_REF_LO       4
`define SBC_ST_LOCK_BIT     8
`define SBC_ST_RUN_BIT      9
`define SBC_ST_FLASH_BIT    10
`define SBC_ST_RSVD_BIT     11

// Cycles after reset release during which straps are still followed.
`define SBC_SETTLE_CYC      4'h8
`define SBC_SETTLE_W        4

`endif

// File: rtl/sbc_pkg.sv
// Types of the strap boot configuration decoder.
// Assumes nothing beyond the defines header for widths.
`include "sbc_defines.svh"

package sbc_pkg;

  // Boot and CPU run control states, one-hot.
  typedef enum logic [2:0]
  {
    SBC_SAMPLE = 3'h1,
    SBC_HELD   = 3'h2,
    SBC_RUN    = 3'h4
  } sbc_state_t;

  // Decoded reference frequency selection.
  typedef enum logic [1:0]
  {
    SBC_F125   = 2'h0,
    SBC_F156   = 2'h1,
    SBC_F250   = 2'h2,
    SBC_F25    = 2'h3
  } sbc_freq_t;

  // Raw strap vector.
  typedef logic [`SBC_STRAP_W-1:0] sbc_strap_t;

endpackage : sbc_pkg

// File: rtl/sbc_strap_if.sv
// Carrier for the filtered strap vector between the filter and the decoder.
// Assumes both ends share mclk.
`timescale 1ns/1ps
`include "sbc_defines.svh"

interface sbc_strap_if;
  // Filtered strap levels.
  sbc_pkg::sbc_strap_t level;

  // The filter drives, the decoder reads.
  modport src (output level);
  modport dst (input  level);
endinterface : sbc_strap_if

// File: rtl/sbc_strap_sync.sv
// Three-stage synchroniser and agreement filter for the strap pins.
// Assumes asynchronous pins; an open pin is pulled to 0 by the pad.
`timescale 1ns/1ps
`include "sbc_defines.svh"

module sbc_strap_sync
(
  input  wire logic          mclk,
  input  wire logic          reset_n,
  input  wire logic [`SBC_STRAP_W-1:0] pins,
  sbc_strap_if.src           out
);

  // Synchroniser stages; stage one feeds only stage two.
  logic [`SBC_STRAP_W-1:0] s1_reg;
  logic [`SBC_STRAP_W-1:0] s2_reg;
  logic [`SBC_STRAP_W-1:0] s3_reg;
  logic [`SBC_STRAP_W-1:0] stable_reg;
  logic [`SBC_STRAP_W-1:0] stable_next;

  // A bit changes only once stages two and three agree.
  always_comb
  begin
    stable_next = stable_reg;
    for (int i = 0; i < `SBC_STRAP_W; i++)
    begin
      if (s2_reg[i] == s3_reg[i])
      begin
        stable_next[i] = s3_reg[i];
      end
    end
  end

  // Everything clears to 0, the level of an unconnected strap.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_reg     <= '0;
      s2_reg     <= '0;
      s3_reg     <= '0;
      stable_reg <= '0;
    end
    else
    begin
      s1_reg     <= pins;
      s2_reg     <= s1_reg;
      s3_reg     <= s2_reg;
      stable_reg <= stable_next;
    end
  end

  assign out.level = stable_reg;

endmodule : sbc_strap_sync

// File: rtl/sbc_strap_decoder.sv
// Strap boot configuration decoder: captures the strap pins at reset
// release, holds the decoded boot, endian, debug and clock settings and
// lets software start a held CPU over APB.
// Assumes one clock, mclk at 20 MHz, and an APB master on the same clock.
//
// How it works
// R1 - cfg 00: release CPU, autoboot serial
// R2 - nonzero cfg: hold CPU until manual start
// R3 - cfg 01: serial client, start DDR
// R4 - cfg 10: parallel and serial clients
// R5 - cfg 10/11: start DDR or flash
// R6 - top cfg bit picks endianness
// R7 - debug select low: CPU debug tap
// R8 - debug select high: boundary scan
// R9 - ref select decodes four frequencies
// R10 - board avoids reserved frequency codes
// R11 - open pin reads 0; latch at reset
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "sbc_defines.svh"

module sbc_strap_decoder
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [2:0]  boot_config_straps,
  input  wire logic        debug_port_select_n,
  input  wire logic [2:0]  ref_freq_select,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic             config_locked,
  output logic             cpu_reset_n,
  output logic             cpu_boot_from_serial,
  output logic             cpu_start_from_flash,
  output logic             cpu_big_endian,
  output logic             serial_client_en,
  output logic             parallel_host_port_en,
  output logic             cpu_debug_tap_sel,
  output logic             boundary_scan_sel,
  output sbc_pkg::sbc_freq_t ref_freq_code,
  output logic [17:0]      ref_freq_khz,
  output logic             ref_freq_reserved
);

  // Filtered strap vector from the synchroniser.
  sbc_strap_if strap_bus ();

  // Latched straps, state and software controls.
  sbc_pkg::sbc_strap_t     strap_reg;
  sbc_pkg::sbc_strap_t     strap_next;
  sbc_pkg::sbc_state_t     state_reg;
  sbc_pkg::sbc_state_t     state_next;
  logic [`SBC_SETTLE_W-1:0] settle_reg;
  logic [`SBC_SETTLE_W-1:0] settle_next;
  logic                    flash_reg;
  logic                    flash_next;
  logic [31:0]             rdata_reg;
  logic [31:0]             rdata_next;
  logic                    err_reg;
  logic                    err_next;

  // Register-bus and strap decode terms.
  logic                    setup_phase;
  logic                    wr_ctrl;
  logic                    hit_status;
  logic                    hit_ctrl;
  logic [1:0]              low_cfg;
  logic                    flash_allowed;
  logic                    reserved_code;

  // Pins are packed in a fixed order so one filter serves all of them.
  sbc_strap_sync u_sync
  (
    .mclk    (mclk),
    .reset_n (reset_n),
    .pins    ({ref_freq_select, debug_port_select_n, boot_config_straps}),
    .out     (strap_bus.src)
  );

  // Bus decode; the slave never inserts wait states.
  assign setup_phase = psel && !penable;
  assign hit_status  = (paddr == `SBC_STATUS_OFS);
  assign hit_ctrl    = (paddr == `SBC_CONTROL_OFS);
  assign wr_ctrl     = psel && penable && pwrite && hit_ctrl;
  assign low_cfg     = strap_reg[`SBC_CFG_LO+1:`SBC_CFG_LO];

  // R5 flash start allowed
  assign flash_allowed = low_cfg[1];

  // R10 reserved code flag
  assign reserved_code = !(strap_reg[`SBC_REF_HI:`SBC_REF_LO] == `SBC_REF_125 ||
                           strap_reg[`SBC_REF_HI:`SBC_REF_LO] == `SBC_REF_156 ||
                           strap_reg[`SBC_REF_HI:`SBC_REF_LO] == `SBC_REF_250 ||
                           strap_reg[`SBC_REF_HI:`SBC_REF_LO] == `SBC_REF_25);

  // Capture and CPU run sequencing. Straps are followed while the chip
  // settles after reset and then frozen, so later pin noise cannot move
  // the boot mode of a running system.
  always_comb
  begin
    strap_next  = strap_reg;
    state_next  = state_reg;
    settle_next = settle_reg;
    flash_next  = flash_reg;
    case (state_reg)
      sbc_pkg::SBC_SAMPLE:
      begin
        // R11 sample then freeze
        strap_next  = strap_bus.level;
        settle_next = settle_reg + `SBC_SETTLE_W'(1);
        if (settle_reg == `SBC_SETTLE_CYC - `SBC_SETTLE_W'(1))
        begin
          // R1 automatic boot release
          if (strap_bus.level[`SBC_CFG_LO+1:`SBC_CFG_LO] == 2'h0)
          begin
            state_next = sbc_pkg::SBC_RUN;
          end
          // R2 hold CPU in reset
          else
          begin
            state_next = sbc_pkg::SBC_HELD;
          end
        end
      end
      sbc_pkg::SBC_HELD:
      begin
        // R3 manual start from DDR
        if (wr_ctrl && pwdata[`SBC_CTL_START_BIT])
        begin
          state_next = sbc_pkg::SBC_RUN;
          // R5 flash only where allowed
          flash_next = pwdata[`SBC_CTL_FLASH_BIT] && flash_allowed;
        end
      end
      sbc_pkg::SBC_RUN:
      begin
        // Running is final until the next device reset.
        state_next = sbc_pkg::SBC_RUN;
      end
      default:
      begin
        // An illegal code falls back to sampling, the safe state.
        state_next = sbc_pkg::SBC_SAMPLE;
      end
    endcase
  end

  // Read data and error are set up in the setup cycle, so they stand in
  // flip-flops by the access cycle.
  always_comb
  begin
    rdata_next = rdata_reg;
    err_next   = err_reg;
    if (setup_phase)
    begin
      rdata_next = 32'h0000_0000;
      err_next   = !(hit_status || hit_ctrl);
      if (hit_status && !pwrite)
      begin
        rdata_next[`SBC_ST_CFG_LO+2:`SBC_ST_CFG_LO] = strap_reg[`SBC_CFG_HI:`SBC_CFG_LO];
        rdata_next[`SBC_ST_DBG_BIT]                = strap_reg[`SBC_DBG_BIT];
        rdata_next[`SBC_ST_REF_LO+2:`SBC_ST_REF_LO] = strap_reg[`SBC_REF_HI:`SBC_REF_LO];
        rdata_next[`SBC_ST_LOCK_BIT]               = (state_reg != sbc_pkg::SBC_SAMPLE);
        rdata_next[`SBC_ST_RUN_BIT]                = (state_reg == sbc_pkg::SBC_RUN);
        rdata_next[`SBC_ST_FLASH_BIT]              = flash_reg;
        rdata_next[`SBC_ST_RSVD_BIT]               = reserved_code;
      end
      else if (hit_ctrl && !pwrite)
      begin
        rdata_next[`SBC_CTL_START_BIT] = (state_reg == sbc_pkg::SBC_RUN);
        rdata_next[`SBC_CTL_FLASH_BIT] = flash_reg;
      end
    end
  end

  // State registers; asynchronous reset loads constants only.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_reg  <= '0;
      state_reg  <= sbc_pkg::SBC_SAMPLE;
      settle_reg <= '0;
      flash_reg  <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      err_reg    <= 1'b0;
    end
    else
    begin
      strap_reg  <= strap_next;
      state_reg  <= state_next;
      settle_reg <= settle_next;
      flash_reg  <= flash_next;
      rdata_reg  <= rdata_next;
      err_reg    <= err_next;
    end
  end

  // APB answer; pslverr only qualifies the access cycle.
  assign pready  = 1'b1;
  assign pslverr = psel && penable && err_reg;
  assign prdata  = rdata_reg;

  // The CPU is held until sequencing reaches the run state.
  assign config_locked        = (state_reg != sbc_pkg::SBC_SAMPLE);
  assign cpu_reset_n          = (state_reg == sbc_pkg::SBC_RUN);
  // R1 serial autoboot
  assign cpu_boot_from_serial = (low_cfg == 2'h0);
  assign cpu_start_from_flash = flash_reg;

  // R6 endianness select
  assign cpu_big_endian = strap_reg[`SBC_CFG_ENDIAN_BIT];

  // R3 R4 R5 client modes
  assign serial_client_en      = (low_cfg != 2'h0);
  assign parallel_host_port_en = (low_cfg == 2'h2);

  // R7 CPU debug tap
  assign cpu_debug_tap_sel = !strap_reg[`SBC_DBG_BIT];
  // R8 boundary scan tap
  assign boundary_scan_sel = strap_reg[`SBC_DBG_BIT];

  // R9 frequency decode; reserved codes fall back to the default.
  always_comb
  begin
    ref_freq_reserved = reserved_code;
    case (strap_reg[`SBC_REF_HI:`SBC_REF_LO])
      `SBC_REF_156:
      begin
        ref_freq_code = sbc_pkg::SBC_F156;
        ref_freq_khz  = `SBC_KHZ_156;
      end
      `SBC_REF_250:
      begin
        ref_freq_code = sbc_pkg::SBC_F250;
        ref_freq_khz  = `SBC_KHZ_250;
      end
      `SBC_REF_25:
      begin
        ref_freq_code = sbc_pkg::SBC_F25;
        ref_freq_khz  = `SBC_KHZ_25;
      end
      default:
      begin
        ref_freq_code = sbc_pkg::SBC_F125;
        ref_freq_khz  = `SBC_KHZ_125;
      end
    endcase
  end

endmodule : sbc_strap_decoder

// File: tb/sbc_board_straps.sv
// Board side of the strap pins: one pull-up or pull-down per strap.
// Assumes the bench picks the fitted resistors before reset is asserted.
`timescale 1ns/1ps
module sbc_board_straps
(
  input  wire logic [6:0] pull_up,
  output logic      [2:0] boot_config_straps,
  output logic            debug_port_select_n,
  output logic      [2:0] ref_freq_select
);
  // open reads low
  // A strap with no pull-up rests on its pull-down, so it never floats.
  assign boot_config_straps  = pull_up[2:0];
  assign debug_port_select_n = pull_up[3];
  // defined and reserved codes alike
  // Undefined codes are fitted in the bench's reserved-code scenario and as the inverted straps after each lock.
  assign ref_freq_select     = pull_up[6:4];
endmodule : sbc_board_straps

// File: tb/sbc_strap_decoder_properties.sv
// Checker of the strap decoder, watching its top ports only.
// Assumes a bind onto sbc_strap_decoder and the single clock mclk.
`timescale 1ns/1ps
module sbc_strap_checker
(
  input wire logic               mclk,
  input wire logic               reset_n,
  input wire logic [2:0]         boot_config_straps,
  input wire logic               debug_port_select_n,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               config_locked,
  input wire logic               cpu_reset_n,
  input wire logic               cpu_boot_from_serial,
  input wire logic               cpu_big_endian,
  input wire logic               serial_client_en,
  input wire logic               parallel_host_port_en,
  input wire logic               cpu_debug_tap_sel,
  input wire logic               boundary_scan_sel,
  input wire logic [1:0]         ref_freq_code,
  input wire logic [17:0]        ref_freq_khz,
  input wire logic               ref_freq_reserved
);
  // A start request that takes effect at this access edge.
  logic        start_w;
  // The kHz figure that the decoded code must show.
  logic [17:0] khz_exp;
  assign start_w = psel && penable && pwrite && paddr == 12'h004 && pwdata[0];
  assign khz_exp = (ref_freq_code == sbc_pkg::SBC_F156) ? 18'h2625A :
                   (ref_freq_code == sbc_pkg::SBC_F250) ? 18'h3D090 :
                   (ref_freq_code == sbc_pkg::SBC_F25)  ? 18'h061A8 : 18'h1E848;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  lock_hold_a: assert property (config_locked |=> config_locked) else $error("lock dropped");
  cfg_freeze_a: assert property (config_locked |=> $stable({cpu_big_endian, boundary_scan_sel,
    serial_client_en, parallel_host_port_en, ref_freq_code})) else $error("setting moved");
  lock_time_a: assert property ($rose(reset_n) |-> ##[1:12] config_locked) else $error("no lock");
  auto_boot_a: assert property ($rose(config_locked) |-> cpu_reset_n ==
    (boot_config_straps[1:0] == 2'h0) && cpu_boot_from_serial == cpu_reset_n) else $error("boot mode");
  byte_order_a: assert property ($rose(config_locked) |-> cpu_big_endian == boot_config_straps[2])
    else $error("byte order");
  tap_pick_a: assert property ($rose(config_locked) |-> boundary_scan_sel == debug_port_select_n
    && cpu_debug_tap_sel != boundary_scan_sel) else $error("test port");
  par_mode_a: assert property (parallel_host_port_en |-> serial_client_en && !cpu_boot_from_serial)
    else $error("parallel mode");
  cpu_held_a: assert property (config_locked && !cpu_reset_n && !start_w |=> !cpu_reset_n)
    else $error("cpu left reset");
  cpu_start_a: assert property (config_locked && !cpu_reset_n && start_w |=> cpu_reset_n)
    else $error("cpu not started");
  freq_khz_a: assert property (ref_freq_khz == khz_exp) else $error("frequency value");
  // Main scenarios: held boot, manual start, reserved code.
  cover property ($rose(config_locked) && !cpu_reset_n);
  cover property (start_w && !cpu_reset_n);
  cover property (ref_freq_reserved && config_locked);
endmodule : sbc_strap_checker

// File: tb/testbench.sv
// Self-checking bench: boots all eight boot_config_straps settings, starts held CPUs over APB.
// Assumes the board model drives the straps and the checker is bound below.
`timescale 1ns/1ps
module testbench;
  logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  pull_up;
  logic [2:0]  cfg_w, ref_w, c;
  logic        dbg_w, d;
  logic [1:0]  r;
  logic config_locked, cpu_reset_n, boot_ser, flash, big, ser_en, par_en, tap, bscan, rsvd;
  sbc_pkg::sbc_freq_t fcode;
  logic [17:0] khz;
  int fails, checks;
  logic [2:0]  ref_tab [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  logic [17:0] khz_tab [4] = '{18'h1E848, 18'h2625A, 18'h3D090, 18'h061A8};
  sbc_board_straps board (.pull_up(pull_up), .boot_config_straps(cfg_w), .debug_port_select_n(dbg_w),
    .ref_freq_select(ref_w));
  sbc_strap_decoder DUT (.mclk(mclk), .reset_n(reset_n), .boot_config_straps(cfg_w),
    .debug_port_select_n(dbg_w), .ref_freq_select(ref_w), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .config_locked(config_locked), .cpu_reset_n(cpu_reset_n),
    .cpu_boot_from_serial(boot_ser), .cpu_start_from_flash(flash), .cpu_big_endian(big),
    .serial_client_en(ser_en), .parallel_host_port_en(par_en), .cpu_debug_tap_sel(tap),
    .boundary_scan_sel(bscan), .ref_freq_code(fcode), .ref_freq_khz(khz), .ref_freq_reserved(rsvd));
  // Free-running 20 MHz clock.
  initial
  begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  // Counts and reports one comparison.
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin fails++; $display("[FAIL] %s expected %h seen %h", what, exp, seen); end
  endtask : chk
  task end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // One APB transfer; the request stands until pready is seen at an edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] q, output logic e);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge mclk);
    penable <= 1'h1;
    // The wait ends when pready is seen; it has no limit of its own, so only the watchdog ends a hang.
    do @(posedge mclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    @(posedge mclk);
  endtask : apb
  // Fits straps, then pulses reset; straps stay put well past the lock.
  task boot(input logic [6:0] p);
    int n;
    pull_up <= p;
    @(posedge mclk);
    reset_n <= 1'h0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'h1;
    n = 0;
    do begin @(posedge mclk); n++; end while (config_locked !== 1'h1 && n < 30);
    @(posedge mclk);
  endtask : boot
  // Cuts a hang short.
  initial
  begin
    repeat (5000) @(posedge mclk);
    fails++;
    end_of_test;
  end
  // Main sequence.
  initial
  begin
    reset_n = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 12'h000; pwdata = 32'h0;
    pull_up = 7'h00; fails = 0; checks = 0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'h1;
    for (int i = 0; i < 8; i++)
    begin
      c = i[2:0]; d = i[0]; r = i[1:0];
      boot({ref_tab[r], d, c});
      chk("cpu_run", cpu_reset_n, c[1:0] == 2'h0);
      chk("boot_serial", boot_ser, c[1:0] == 2'h0);
      chk("serial_en", ser_en, c[1:0] != 2'h0);
      chk("parallel_en", par_en, c[1:0] == 2'h2);
      chk("endian", big, c[2]);
      chk("debug_tap", tap, !d);
      chk("bscan", bscan, d);
      chk("freq_code", fcode, r);
      chk("freq_khz", khz, khz_tab[r]);
      chk("no_reserved", rsvd, 1'h0);
      apb(1'h0, 12'h000, 32'h0, rd, err);
      chk("status", rd[11:0], {2'h0, c[1:0] == 2'h0, 1'h1, 1'h0, ref_tab[r], d, c});
      chk("status_err", err, 1'h0);
      pull_up <= ~{ref_tab[r], d, c};
      apb(1'h1, 12'h004, 32'h3, rd, err);
      repeat (4) @(posedge mclk);
      chk("started", cpu_reset_n, 1'h1);
      chk("flash", flash, c[1]);
      chk("frozen", {big, bscan, fcode}, {c[2], d, r});
    end
    boot(7'h70);
    chk("reserved", rsvd, 1'h1);
    chk("reserved_code", fcode, 2'h0);
    apb(1'h0, 12'h008, 32'h0, rd, err);
    chk("unmapped_err", err, 1'h1);
    end_of_test;
  end
endmodule : testbench
bind sbc_strap_decoder sbc_strap_checker u_chk (.mclk, .reset_n, .boot_config_straps, .debug_port_select_n,
  .psel, .penable, .pwrite, .paddr, .pwdata, .config_locked, .cpu_reset_n, .cpu_boot_from_serial,
  .cpu_big_endian, .serial_client_en, .parallel_host_port_en, .cpu_debug_tap_sel, .boundary_scan_sel,
  .ref_freq_code, .ref_freq_khz, .ref_freq_reserved);
